// *** hw/cts_pkg.sv ***
// Package for the current-transformer circuit supervision block: types, encodings and constants
package cts_pkg;

  // Clock and alarm-delay time base
  localparam int CLK_PERIOD_NS = 40;
  localparam int ALARM_STEP_NS = 5000000;
  localparam int TICK_CYCLES = (ALARM_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [18:0] DELAY_STEPS_RST = 19'h00064;

  // Percent scaling and hysteresis figures
  localparam logic [79:0] PCT_SCALE = 80'h0000_0000_0000_0000_2710;
  localparam logic [79:0] HYS_RELEASE_ABOVE = 80'h0000_0000_0000_0000_24c1;
  localparam logic [79:0] HYS_RELEASE_BELOW = 80'h0000_0000_0000_0000_2971;
  localparam logic [79:0] RATIO_SCALE_SQ = 80'h0000_0000_0000_05f5_e100;

  // Square root of three in Q14
  localparam logic signed [16:0] SQRT3_Q14 = 17'sh06eda;
  localparam int SQRT3_FRAC = 14;

  // Reset values of the setting group
  localparam logic [15:0] UPPER_RST = 16'h0078;
  localparam logic [15:0] LOWER_RST = 16'h000a;
  localparam logic [13:0] MINMAX_RST = 14'h03e8;
  localparam logic [13:0] SEQ_RST = 14'h1324;
  localparam logic [15:0] SUMDIFF_RST = 16'h000a;

  typedef logic [79:0] cts_wide_t;
  typedef logic [47:0] cts_mag_t;

  typedef enum logic [2:0] {
    MODE_ON = 3'b000,
    MODE_BLOCKED = 3'b001,
    MODE_TEST = 3'b010,
    MODE_TEST_BLOCKED = 3'b011,
    MODE_OFF = 3'b100
  } cts_mode_t;

  typedef enum logic [1:0] {
    FORCE_NORMAL = 2'b00,
    FORCE_ALARM = 2'b01,
    FORCE_BLOCKED = 2'b10
  } cts_force_t;

  typedef enum logic [1:0] {
    RES_NONE = 2'b00,
    RES_ONE = 2'b01,
    RES_TWO = 2'b10
  } cts_ressel_t;

  typedef struct packed {
    logic signed [15:0] re;
    logic signed [15:0] im;
  } cts_phasor_t;

  typedef struct packed {
    logic signed [23:0] re;
    logic signed [23:0] im;
  } cts_vec_t;

  typedef struct packed {
    cts_phasor_t phaseA;
    cts_phasor_t phaseB;
    cts_phasor_t phaseC;
    cts_phasor_t resOne;
    cts_phasor_t resTwo;
  } cts_meas_t;

  typedef struct packed {
    logic [15:0] upperPhaseThreshold;
    logic [15:0] lowerPhaseThreshold;
    logic [13:0] minMaxPhaseRatio;
    logic [13:0] sequenceRatioThreshold;
    logic [15:0] sumDiffThreshold;
    logic [18:0] alarmDelaySteps;
  } cts_group_t;

  typedef struct packed {
    cts_ressel_t residualSelect;
    logic residualMonitorEn;
    logic residualSubtract;
    cts_mode_t nodeOperatingMode;
    cts_force_t forceStatus;
  } cts_static_t;

endpackage

// *** hw/cts_supervision.sv ***
// Current-transformer circuit supervision: pattern tests, delay timer, mode and forcing
//
// Contract
// - Pattern present only when every threshold and ratio test passes together.
// - No phase magnitude may exceed the upper phase threshold.
// - At least one phase magnitude exceeds the lower phase threshold.
// - At least one phase magnitude lies below the lower phase threshold.
// - Minimum over maximum phase magnitude must be under the min-max ratio.
// - Negative over positive sequence magnitude must exceed the sequence ratio.
// - With residual monitoring, phase-plus-residual sum magnitude must exceed sum setting.
// - Alarm only after the pattern persists for the alarm delay.
// - Work from fundamental-frequency phasors of all current channels.
// - Supervise channel angles as well as magnitudes.
// - Derive positive and negative sequence currents from the phase phasors.
// - Residual selector: none, channel one or channel two; none by default.
// - Residual monitoring switched on or off independently.
// - Residual polarity adds or subtracts the residual; add by default.
// - Compensation command stores present residual sum so it reads zero.
// - Node mode On, Blocked, Test, Test/Blocked or Off; On by default.
// - Forcing overrides output to Normal, Alarm or Blocked; Normal default.
// - Selection, polarity, mode and forcing are static, outside setting groups.
// - Threshold tests use 97 and 103 percent hysteresis around the setting.
// - Alarm delay set in 5 ms steps, default 0.5 s.
// - External block input sampled at start of each program cycle.
`timescale 1ns/1ps

module cts_supervision import cts_pkg::*; #(
  parameter int TICK_LEN = TICK_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Measurement, one program cycle per strobe
  input wire logic measValid,
  input wire cts_meas_t meas,
  // Settings and commands
  input wire cts_group_t groupSet,
  input wire cts_static_t staticSet,
  input wire logic blockIn,
  input wire logic compCmd,
  // Status
  output logic alarmOut,
  output logic startOut,
  output logic blockedOut,
  output logic testOut,
  output cts_vec_t residualSum
);

  // Magnitude squared of a widened phasor
  function automatic cts_mag_t magSq(input cts_vec_t v);
    logic signed [47:0] pr;
    logic signed [47:0] pi;
    begin
      pr = v.re * v.re;
      pi = v.im * v.im;
      magSq = cts_mag_t'(pr) + cts_mag_t'(pi);
    end
  endfunction

  // Sign-extend a 16-bit input phasor
  function automatic cts_vec_t widen(input cts_phasor_t p);
    cts_vec_t w;
    begin
      w.re = 24'(p.re);
      w.im = 24'(p.im);
      widen = w;
    end
  endfunction

  // Multiply by root three
  function automatic logic signed [23:0] mulRt3(input logic signed [23:0] v);
    logic signed [40:0] p;
    begin
      p = v * SQRT3_Q14;
      mulRt3 = p[SQRT3_FRAC+23:SQRT3_FRAC];
    end
  endfunction

  // Twice the rotation by +120 (sq=0) or +240 degrees (sq=1)
  function automatic cts_vec_t rot2(input cts_vec_t x, input logic sq);
    cts_vec_t r;
    begin
      if (sq) begin
        r.re = -x.re + mulRt3(x.im);
        r.im = -mulRt3(x.re) - x.im;
      end else begin
        r.re = -x.re - mulRt3(x.im);
        r.im = mulRt3(x.re) - x.im;
      end
      rot2 = r;
    end
  endfunction

  function automatic cts_vec_t vAdd(input cts_vec_t a, input cts_vec_t b);
    cts_vec_t r;
    begin
      r.re = a.re + b.re;
      r.im = a.im + b.im;
      vAdd = r;
    end
  endfunction

  function automatic cts_vec_t vSub(input cts_vec_t a, input cts_vec_t b);
    cts_vec_t r;
    begin
      r.re = a.re - b.re;
      r.im = a.im - b.im;
      vSub = r;
    end
  endfunction

  // Threshold test on squared magnitude with release hysteresis
  function automatic logic hystCmp(input cts_mag_t m2, input logic [15:0] thr, input logic prev,
                                   input logic above);
    cts_wide_t lhs;
    cts_wide_t t2;
    begin
      lhs = cts_wide_t'(m2) * PCT_SCALE;
      t2 = cts_wide_t'(thr) * cts_wide_t'(thr);
      if (above) begin
        hystCmp = lhs > t2 * (prev ? HYS_RELEASE_ABOVE : PCT_SCALE);
      end else begin
        hystCmp = lhs < t2 * (prev ? HYS_RELEASE_BELOW : PCT_SCALE);
      end
    end
  endfunction

  // Ratio test num/den against a setting in 0.01 percent, on squares
  function automatic logic ratioCmp(input cts_mag_t num2, input cts_mag_t den2, input logic [13:0] r,
                                    input logic above);
    cts_wide_t lhs;
    cts_wide_t rhs;
    begin
      lhs = cts_wide_t'(num2) * RATIO_SCALE_SQ;
      rhs = cts_wide_t'(r) * cts_wide_t'(r) * cts_wide_t'(den2);
      ratioCmp = above ? (lhs > rhs) : (lhs < rhs);
    end
  endfunction

  // Channel phasors carry angle as well as magnitude
  cts_vec_t vecA, vecB, vecC, vecRes, rawSum, compSum, seqPos, seqNeg;
  cts_mag_t magA, magB, magC, magMin, magMax, magPos, magNeg, magSum;
  assign vecA = widen(meas.phaseA);
  assign vecB = widen(meas.phaseB);
  assign vecC = widen(meas.phaseC);
  assign magA = magSq(vecA);
  assign magB = magSq(vecB);
  assign magC = magSq(vecC);

  // Residual source and polarity; unused code falls back to no residual
  cts_vec_t selRes;
  always_comb begin
    unique case (staticSet.residualSelect)
      RES_ONE: selRes = widen(meas.resOne);
      RES_TWO: selRes = widen(meas.resTwo);
      default: selRes = '0;
    endcase
  end
  assign vecRes = staticSet.residualSubtract ? vSub('0, selRes) : selRes;

  // Vector sum keeps angles, so a reversed or rotated channel shows up here
  assign rawSum = vAdd(vAdd(vecA, vecB), vAdd(vecC, vecRes));

  // Last strobed raw sum; phasors between strobes are not measurements and must not be compensated
  cts_vec_t rawHeld_r;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rawHeld_r <= '0;
    end else if (measValid) begin
      rawHeld_r <= rawSum;
    end
  end

  // Natural unbalance offset, taken from the present program cycle's sum
  cts_vec_t offset_r;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      offset_r <= '0;
    end else if (compCmd) begin
      offset_r <= measValid ? rawSum : rawHeld_r;
    end
  end
  assign compSum = vSub(rawSum, offset_r);
  assign magSum = magSq(compSum);

  // Sequence components, both scaled by three times two
  assign seqPos = vAdd(vAdd(vAdd(vecA, vecA), rot2(vecB, 1'b0)), rot2(vecC, 1'b1));
  assign seqNeg = vAdd(vAdd(vAdd(vecA, vecA), rot2(vecB, 1'b1)), rot2(vecC, 1'b0));
  assign magPos = magSq(seqPos);
  assign magNeg = magSq(seqNeg);

  // Smallest and largest phase magnitude; squares keep the order
  always_comb begin
    magMin = magA;
    magMax = magA;
    if (magB < magMin) magMin = magB;
    if (magC < magMin) magMin = magC;
    if (magB > magMax) magMax = magB;
    if (magC > magMax) magMax = magC;
  end

  // Hysteretic comparator states, per phase and for the sum
  logic [2:0] highHit_r, lowAbove_r, lowBelow_r;
  logic [2:0] highHit_nxt, lowAbove_nxt, lowBelow_nxt;
  logic sumHit_r, sumHit_nxt;
  cts_mag_t magPh [3];
  assign magPh[0] = magA;
  assign magPh[1] = magB;
  assign magPh[2] = magC;

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      highHit_nxt[i] = hystCmp(magPh[i], groupSet.upperPhaseThreshold, highHit_r[i], 1'b1);
      lowAbove_nxt[i] = hystCmp(magPh[i], groupSet.lowerPhaseThreshold, lowAbove_r[i], 1'b1);
      lowBelow_nxt[i] = hystCmp(magPh[i], groupSet.lowerPhaseThreshold, lowBelow_r[i], 1'b0);
    end
    sumHit_nxt = hystCmp(magSum, groupSet.sumDiffThreshold, sumHit_r, 1'b1);
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      highHit_r <= '0;
      lowAbove_r <= '0;
      lowBelow_r <= '0;
      sumHit_r <= 1'b0;
    end else if (measValid) begin
      highHit_r <= highHit_nxt;
      lowAbove_r <= lowAbove_nxt;
      lowBelow_r <= lowBelow_nxt;
      sumHit_r <= sumHit_nxt;
    end
  end

  // Combined pattern for this program cycle
  logic resActive, ratioOk, seqOk, sumOk, patNxt;
  assign resActive = staticSet.residualMonitorEn && (staticSet.residualSelect != RES_NONE);
  assign ratioOk = ratioCmp(magMin, magMax, groupSet.minMaxPhaseRatio, 1'b0);
  assign seqOk = ratioCmp(magNeg, magPos, groupSet.sequenceRatioThreshold, 1'b1);
  assign sumOk = resActive ? sumHit_nxt : 1'b1;
  assign patNxt = !(|highHit_nxt) && (|lowAbove_nxt) && (|lowBelow_nxt) && ratioOk && seqOk && sumOk;

  // Mode and block decode; the block input is taken with the measurement strobe
  logic blockSeen, modeBlocked, modeOff, active;
  assign blockSeen = measValid && blockIn;
  always_comb begin
    unique case (staticSet.nodeOperatingMode)
      MODE_ON: begin
        modeBlocked = 1'b0;
        modeOff = 1'b0;
      end
      MODE_BLOCKED, MODE_TEST_BLOCKED: begin
        modeBlocked = 1'b1;
        modeOff = 1'b0;
      end
      MODE_TEST: begin
        modeBlocked = 1'b0;
        modeOff = 1'b0;
      end
      default: begin
        modeBlocked = 1'b0;
        modeOff = 1'b1;
      end
    endcase
  end
  assign active = !modeOff && !modeBlocked && !blockSeen;

  // Pattern register; cleared while the function cannot act
  logic pattern_r;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pattern_r <= 1'b0;
    end else if (measValid) begin
      pattern_r <= patNxt && active;
    end else if (modeOff || modeBlocked) begin
      pattern_r <= 1'b0;
    end
  end

  // 5 ms step divider, held in phase with the pattern start
  localparam int TICK_W = $clog2(TICK_LEN + 1);
  logic [TICK_W-1:0] tickCnt_r;
  logic tickEn;
  assign tickEn = pattern_r && (tickCnt_r == TICK_W'(TICK_LEN - 1));
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tickCnt_r <= '0;
    end else if (!pattern_r || tickEn) begin
      tickCnt_r <= '0;
    end else begin
      tickCnt_r <= tickCnt_r + TICK_W'(1);
    end
  end

  // Delay step counter; a drop in the pattern restarts it
  logic [18:0] stepCnt_r;
  logic timerDone;
  assign timerDone = stepCnt_r >= groupSet.alarmDelaySteps;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      stepCnt_r <= '0;
    end else if (!pattern_r) begin
      stepCnt_r <= '0;
    end else if (tickEn && !(&stepCnt_r)) begin
      stepCnt_r <= stepCnt_r + 19'h00001;
    end
  end

  // Output status; forcing overrides the measured result
  logic alarm_nxt, blocked_nxt;
  always_comb begin
    alarm_nxt = alarmOut;
    blocked_nxt = blockedOut;
    unique case (staticSet.forceStatus)
      FORCE_ALARM: begin
        alarm_nxt = 1'b1;
        blocked_nxt = 1'b0;
      end
      FORCE_BLOCKED: begin
        alarm_nxt = 1'b0;
        blocked_nxt = 1'b1;
      end
      default: begin
        if (modeOff || modeBlocked) begin
          alarm_nxt = 1'b0;
          blocked_nxt = modeBlocked;
        end else if (measValid) begin
          // Needs the pattern last cycle and now, so a single bad cycle never alarms
          alarm_nxt = patNxt && active && pattern_r && timerDone;
          blocked_nxt = blockSeen;
        end
      end
    endcase
  end

  // Group settings feed thresholds, ratios and the alarm delay; static settings arrive on their own port
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      alarmOut <= 1'b0;
      blockedOut <= 1'b0;
      testOut <= 1'b0;
      startOut <= 1'b0;
      residualSum <= '0;
    end else begin
      alarmOut <= alarm_nxt;
      blockedOut <= blocked_nxt;
      testOut <= (staticSet.nodeOperatingMode == MODE_TEST) ||
                 (staticSet.nodeOperatingMode == MODE_TEST_BLOCKED);
      startOut <= (staticSet.forceStatus == FORCE_NORMAL) && !modeOff && !modeBlocked &&
                  (measValid ? (patNxt && active) : startOut);
      if (measValid) residualSum <= compSum;
    end
  end

  // Checks
  logic forcedNormal;
  cts_vec_t heldComp;
  assign forcedNormal = staticSet.forceStatus == FORCE_NORMAL;
  // Compensated value of the last strobed sum
  assign heldComp = vSub(rawHeld_r, offset_r);

  AST_HIGH_VETO: assert property (@(posedge sys_clk) disable iff (!rst_b)
    measValid && (|highHit_nxt) |=> !pattern_r)
    else $error("pattern set with a phase above upper threshold");
  AST_NEED_ABOVE: assert property (@(posedge sys_clk) disable iff (!rst_b)
    measValid && !(|lowAbove_nxt) |=> !pattern_r)
    else $error("pattern set with no phase above lower threshold");
  AST_NEED_BELOW: assert property (@(posedge sys_clk) disable iff (!rst_b)
    measValid && !(|lowBelow_nxt) |=> !pattern_r)
    else $error("pattern set with no phase below lower threshold");
  AST_ALL_TESTS: assert property (@(posedge sys_clk) disable iff (!rst_b)
    measValid && !(ratioOk && seqOk && sumOk) |=> !pattern_r && !startOut)
    else $error("pattern set while a ratio test failed");
  AST_SUM_SKIP: assert property (@(posedge sys_clk) disable iff (!rst_b)
    measValid && !resActive && !(|highHit_nxt) && (|lowAbove_nxt) && (|lowBelow_nxt) && ratioOk && seqOk &&
    active |=> pattern_r)
    else $error("sum test applied while residual monitoring inactive");
  AST_COMP_ZERO: assert property (@(posedge sys_clk) disable iff (!rst_b)
    compCmd |=> heldComp == '0)
    else $error("compensated residual not zero after compensation");
  AST_DROP_CLEAR: assert property (@(posedge sys_clk) disable iff (!rst_b)
    measValid && !patNxt |=> ##1 stepCnt_r == '0)
    else $error("delay counter kept value after pattern drop");
  AST_ALARM_FALL: assert property (@(posedge sys_clk) disable iff (!rst_b)
    measValid && !patNxt && forcedNormal |=> !alarmOut)
    else $error("alarm held after pattern vanished");
  AST_ALARM_DELAY: assert property (@(posedge sys_clk) disable iff (!rst_b)
    forcedNormal && $rose(alarmOut) |-> $past(stepCnt_r) >= $past(groupSet.alarmDelaySteps))
    else $error("alarm raised before the delay expired");
  AST_OFF_QUIET: assert property (@(posedge sys_clk) disable iff (!rst_b)
    forcedNormal && staticSet.nodeOperatingMode == MODE_OFF |=> !alarmOut && !blockedOut)
    else $error("output active with mode off");
  AST_FORCE: assert property (@(posedge sys_clk) disable iff (!rst_b)
    staticSet.forceStatus == FORCE_ALARM |=> alarmOut && !blockedOut)
    else $error("forced alarm not shown");
  AST_BLOCK_IN: assert property (@(posedge sys_clk) disable iff (!rst_b)
    measValid && blockIn && forcedNormal |=> !alarmOut && !pattern_r)
    else $error("alarm despite sampled block input");

  COV_ALARM: cover property (@(posedge sys_clk) disable iff (!rst_b) forcedNormal && $rose(alarmOut));
  COV_RESTART: cover property (@(posedge sys_clk) disable iff (!rst_b)
    pattern_r && stepCnt_r != '0 ##1 !pattern_r);
  COV_SUM: cover property (@(posedge sys_clk) disable iff (!rst_b) measValid && resActive && patNxt);
  COV_BLOCK: cover property (@(posedge sys_clk) disable iff (!rst_b) $rose(blockedOut));

endmodule // cts_supervision

// *** tb/cts_front_end.sv ***
// Measurement front end model: presents phasors and strobes one program cycle
`timescale 1ns/1ps

module cts_front_end import cts_pkg::*; (
  // Clock
  input wire logic sys_clk,
  // Measurement towards the block
  output cts_meas_t meas,
  output logic measValid
);
  // Idle front end until the first strobe
  initial begin
    meas = '0;
    measValid = 1'b0;
  end

  // One strobe, then scramble the phasors, since the block must ignore them off strobe
  task automatic send(input cts_meas_t v);
    @(negedge sys_clk);
    meas = v;
    measValid = 1'b1;
    @(negedge sys_clk);
    measValid = 1'b0;
    meas = ~v;
  endtask
endmodule // cts_front_end

// *** tb/tb_cts_supervision.sv ***
// Self-checking bench for the current-transformer circuit supervision block
`timescale 1ns/1ps

module tb_cts_supervision import cts_pkg::*;;
  localparam int LIMIT = 3000;
  // Expected outputs per mode (index is the mode code) and per forcing code
  localparam logic [4:0] MODE_ALARM = 5'h05;
  localparam logic [4:0] MODE_BLOCK = 5'h0a;
  localparam logic [4:0] TEST_EXP = 5'h0c;
  localparam logic [2:0] FORCE_AL = 3'h2;
  localparam logic [2:0] FORCE_BL = 3'h4;

  logic sys_clk;
  logic rst_b;
  logic measValid;
  cts_meas_t meas;
  cts_group_t grp;
  cts_static_t sta;
  logic blockIn;
  logic compCmd;
  logic alarmOut;
  logic startOut;
  logic blockedOut;
  logic testOut;
  cts_vec_t residualSum;
  int errors;
  int nChecks;
  int cycles;
  cts_meas_t brk;
  cts_meas_t hlt;
  cts_meas_t big;

  cts_front_end FE (.sys_clk(sys_clk), .meas(meas), .measValid(measValid));

  // Short tick keeps the alarm delay to about a dozen cycles
  cts_supervision #(.TICK_LEN(4)) DUT (
    .sys_clk(sys_clk), .rst_b(rst_b), .measValid(measValid), .meas(meas), .groupSet(grp),
    .staticSet(sta), .blockIn(blockIn), .compCmd(compCmd), .alarmOut(alarmOut), .startOut(startOut),
    .blockedOut(blockedOut), .testOut(testOut), .residualSum(residualSum)
  );

  // 25 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // Hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      errors++;
      results();
    end
  end

  function automatic cts_phasor_t ph(input int re, input int im);
    return '{re: 16'(re), im: 16'(im)};
  endfunction

  function automatic logic [47:0] vs(input int re, input int im);
    return {24'(re), 24'(im)};
  endfunction

  task automatic check(input string what, input logic [47:0] exp, input logic [47:0] got);
    nChecks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic run(input cts_meas_t m, input int n);
    repeat (n) FE.send(m);
  endtask

  // One strobe, then the pattern flag
  task automatic pat(input cts_meas_t m, input logic e);
    run(m, 1);
    check("startOut", e, startOut);
  endtask

  // One strobe with residual phasors, then pattern flag and compensated sum
  task automatic res(input cts_phasor_t r1, input cts_phasor_t r2, input logic e, input logic [47:0] s);
    cts_meas_t m;
    m = brk;
    m.resOne = r1;
    m.resTwo = r2;
    pat(m, e);
    check("residualSum", s, residualSum);
  endtask

  task automatic done(input string name);
    $display("Test %s finished", name);
  endtask

  task automatic results;
    $display("Checks %0d mismatches %0d", nChecks, errors);
    if (errors == 0 && nChecks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Main sequence
  initial begin
    errors = 0;
    nChecks = 0;
    cycles = 0;
    rst_b = 1'b0;
    blockIn = 1'b0;
    compCmd = 1'b0;
    sta = '{RES_NONE, 1'b0, 1'b0, MODE_ON, FORCE_NORMAL};
    grp = '{UPPER_RST, LOWER_RST, MINMAX_RST, SEQ_RST, SUMDIFF_RST, 19'h00003};
    // Phase A open, B and C healthy at 120 degrees apart
    brk = '{ph(0, 0), ph(-50, -87), ph(-50, 87), ph(0, 0), ph(0, 0)};
    hlt = '{ph(100, 0), ph(-50, -87), ph(-50, 87), ph(0, 0), ph(0, 0)};
    big = '{ph(0, 0), ph(-100, -173), ph(-100, 173), ph(0, 0), ph(0, 0)};
    repeat (10) @(negedge sys_clk);
    rst_b = 1'b1;
    check("alarmOut", 1'b0, alarmOut);
    check("blockedOut", 1'b0, blockedOut);
    check("residualSum", 48'h0, residualSum);
    done("reset");

    // Upper, min-max and sequence tests each alone keep the pattern away; hlt and zero currents fail several tests
    pat(brk, 1'b1);
    pat(hlt, 1'b0);
    pat('0, 1'b0);
    pat(big, 1'b0);
    pat(brk, 1'b1);
    grp.minMaxPhaseRatio = 14'h0000;
    pat(brk, 1'b0);
    grp.minMaxPhaseRatio = MINMAX_RST;
    grp.sequenceRatioThreshold = 14'h13ec;
    pat(brk, 1'b0);
    grp.sequenceRatioThreshold = SEQ_RST;
    pat(brk, 1'b1);
    done("pattern");

    // Upper test picks up above 100, holds at 102, releases only under 97 percent of 105
    grp.upperPhaseThreshold = 16'h0064;
    pat(brk, 1'b0);
    grp.upperPhaseThreshold = 16'h0066;
    pat(brk, 1'b0);
    grp.upperPhaseThreshold = 16'h0069;
    pat(brk, 1'b1);
    grp.upperPhaseThreshold = UPPER_RST;
    done("hysteresis");

    // Three steps of four cycles; any drop restarts the count
    pat(hlt, 1'b0);
    run(brk, 3);
    check("alarmOut", 1'b0, alarmOut);
    run(brk, 6);
    check("alarmOut", 1'b1, alarmOut);
    pat(hlt, 1'b0);
    check("alarmOut", 1'b0, alarmOut);
    run(brk, 3);
    check("alarmOut", 1'b0, alarmOut);
    done("delay");

    // Every mode after a long pattern
    for (int i = 0; i < 5; i++) begin
      sta.nodeOperatingMode = cts_mode_t'(i);
      run(brk, 12);
      check("alarmOut", MODE_ALARM[i], alarmOut);
      check("blockedOut", MODE_BLOCK[i], blockedOut);
      check("testOut", TEST_EXP[i], testOut);
    end
    sta.nodeOperatingMode = MODE_ON;
    done("mode");

    // Every forcing code on healthy currents
    for (int i = 0; i < 3; i++) begin
      sta.forceStatus = cts_force_t'(i);
      run(hlt, 2);
      check("alarmOut", FORCE_AL[i], alarmOut);
      check("blockedOut", FORCE_BL[i], blockedOut);
    end
    sta.forceStatus = FORCE_NORMAL;
    done("force");

    // External block taken with a strobe clears alarm and timer
    run(brk, 12);
    check("alarmOut", 1'b1, alarmOut);
    blockIn = 1'b1;
    run(brk, 1);
    check("blockedOut", 1'b1, blockedOut);
    check("alarmOut", 1'b0, alarmOut);
    blockIn = 1'b0;
    run(brk, 1);
    check("alarmOut", 1'b0, alarmOut);
    done("block");

    // Residual sum, selector and polarity
    sta.residualMonitorEn = 1'b1;
    sta.residualSelect = RES_ONE;
    res(ph(100, 0), ph(0, 0), 1'b0, vs(0, 0));
    sta.residualSubtract = 1'b1;
    res(ph(100, 0), ph(0, 0), 1'b1, vs(-200, 0));
    sta.residualSubtract = 1'b0;
    sta.residualSelect = RES_TWO;
    res(ph(100, 0), ph(30, 0), 1'b1, vs(-70, 0));
    sta.residualSelect = RES_NONE;
    res(ph(100, 0), ph(30, 0), 1'b1, vs(-100, 0));
    sta.residualSelect = RES_ONE;
    sta.residualMonitorEn = 1'b0;
    res(ph(100, 0), ph(0, 0), 1'b1, vs(0, 0));
    sta.residualMonitorEn = 1'b1;
    done("residual");

    // Compensation zeroes the present sum, so the sum test then fails
    res(ph(40, 0), ph(0, 0), 1'b1, vs(-60, 0));
    compCmd = 1'b1;
    @(negedge sys_clk);
    compCmd = 1'b0;
    res(ph(40, 0), ph(0, 0), 1'b0, vs(0, 0));
    done("compensation");
    results();
  end
endmodule // tb_cts_supervision
